// [src/crg_pkg.sv]
// Shared constants and types for the register file and wide access guard
package crg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Working register file
	localparam int         REG_COUNT     = 32;
	localparam int         PTR_BYTES     = 6;
	localparam logic [4:0] PTR_BASE      = 5'h1a;
	localparam logic [1:0] PTR_SEL_LOW   = 2'h0;
	localparam logic [1:0] PTR_SEL_MID   = 2'h1;
	localparam logic [1:0] PTR_SEL_HIGH  = 2'h2;

	typedef enum logic [1:0] {
		PTR_DISP,
		PTR_POST_INC,
		PTR_PRE_DEC
	} crg_ptr_mode_type;

	////////////////////////////////////////////////////////////////////////////////
	// Core register block offsets
	localparam logic [5:0] OFS_KEY       = 6'h04;
	localparam logic [5:0] OFS_SP_LOW    = 6'h0d;
	localparam logic [5:0] OFS_SP_HIGH   = 6'h0e;
	localparam logic [5:0] OFS_FLAGS     = 6'h0f;

	////////////////////////////////////////////////////////////////////////////////
	// Protection key
	localparam logic [7:0] SIG_SELF_PROG = 8'h9d;
	localparam logic [7:0] SIG_IO_WRITE  = 8'hd8;
	localparam int         KEY_IO_BIT    = 0;
	localparam int         KEY_SPM_BIT   = 1;
	localparam logic [2:0] UNLOCK_INSTR  = 3'h4;
	localparam logic [2:0] SP_HOLD_INSTR = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  FLAGS_RESET  = 8'h00;
	localparam logic [15:0] SP_RESET     = 16'hffff;

endpackage

// [src/crg_regfile_mem.sv]
// Working register storage with one byte write port, one pair write port, two read ports
`timescale 1ns/100ps
module crg_regfile_mem (
	input  wire logic       clock,      // Processor clock
	input  wire logic       rst,        // Synchronous reset, high
	input  wire logic       wr_en,      // Byte write strobe
	input  wire logic [4:0] wr_addr,    // Byte write address
	input  wire logic [7:0] wr_data,    // Byte write data
	input  wire logic       pair_en,    // Pointer pair write strobe
	input  wire logic [4:0] pair_addr,  // Even address of the pair
	input  wire logic [15:0] pair_data, // Pair data, low byte at even address
	input  wire logic [4:0] rd_addr_a,  // Read port A address
	input  wire logic [4:0] rd_addr_b,  // Read port B address
	output logic      [7:0] rd_data_a,  // Read port A data, registered
	output logic      [7:0] rd_data_b   // Read port B data, registered
);

	logic [7:0] mem [0:crg_pkg::REG_COUNT-1];

	////////////////////////////////////////////////////////////////////////////////
	// Byte write comes last so it overrides the pair on a shared byte
	always_ff @(posedge clock) begin
		if (pair_en) begin
			mem[{pair_addr[4:1], 1'b0}] <= pair_data[7:0];
			mem[{pair_addr[4:1], 1'b1}] <= pair_data[15:8];
		end
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read returns the old value on a same-cycle write; the pipeline forwards
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data_a <= 8'h00;
			rd_data_b <= 8'h00;
		end else begin
			rd_data_a <= mem[rd_addr_a];
			rd_data_b <= mem[rd_addr_b];
		end
	end

endmodule // crg_regfile_mem

// [src/crg_wide_stage.sv]
// Multi-byte register reached through byte staging registers
`timescale 1ns/100ps
module crg_wide_stage #(
	parameter int                      BYTES       = 2,
	parameter logic [8*BYTES-1:0]      RESET_VALUE = '0
) (
	input  wire logic                 clock,     // Processor clock
	input  wire logic                 rst,       // Synchronous reset, high
	input  wire logic                 wr_en,     // Byte write strobe
	input  wire logic                 rd_en,     // Byte read strobe
	input  wire logic [1:0]           byte_sel,  // Byte index, 0 is least significant
	input  wire logic [7:0]           wdata,     // Write data
	output logic      [8*BYTES-1:0]   value_reg, // Live register value
	output logic      [7:0]           rd_byte    // Read data for byte_sel
);

	logic [7:0]             temp_reg [0:BYTES-2];
	logic [8*BYTES-9:0]     temp_flat;

	genvar i;
	generate
		for (i = 0; i < BYTES - 1; i++) begin : g_temp
			assign temp_flat[8*i +: 8] = temp_reg[i];
			always_ff @(posedge clock) begin
				if (rst) begin
					temp_reg[i] <= 8'h00;
				end else if (wr_en && byte_sel == 2'(i)) begin
					temp_reg[i] <= wdata;
				end else if (rd_en && byte_sel == 2'h0) begin
					temp_reg[i] <= value_reg[8*(i+1) +: 8];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Top byte commits all
	always_ff @(posedge clock) begin
		if (rst) begin
			value_reg <= RESET_VALUE;
		end else if (wr_en && byte_sel == 2'(BYTES - 1)) begin
			value_reg <= {wdata, temp_flat};
		end
	end

	always_comb begin
		rd_byte = value_reg[7:0];
		for (int k = 0; k < BYTES - 1; k++) begin
			if (byte_sel == 2'(k + 1)) begin
				rd_byte = temp_reg[k];
			end
		end
	end

endmodule // crg_wide_stage

// [src/crg_core.sv]
// Working register file, pointer pairs, core register block and protection key
`timescale 1ns/100ps

// How it works
// - Thirty-two byte registers on their own ports, apart from data memory.
// - Register reads and writes complete each cycle with registered read data.
// - Immediate-form writes always land in registers sixteen to thirty-one.
// - Registers twenty-six to thirty-one form three sixteen-bit pointers.
// - Lower-numbered register holds the pointer low byte, higher the high byte.
// - The top pointer also addresses program memory reads.
// - Pointers support displacement, post-increment and pre-decrement forms.
// - Sixteen-bit registers meet the byte bus through a staging byte.
// - Writing the low byte loads only the staging byte.
// - Writing the high byte commits it and the staged low byte together.
// - Reading the low byte snapshots the high byte into staging.
// - Reading the high byte returns the staged snapshot.
// - Three-byte registers use two staging bytes, top written last.
// - Protected writes and self-programming need a prior unlock signature.
// - Two independent unlock modes: protected writes and self-programming.
// - Protected-write window lasts four retired instructions.
// - Any memory write, memory-controller access or sleep closes the write window.
// - Self-programming window lasts four instructions, closed by memory-controller access or sleep.
// - Interrupts are held off during either window, flags still set.
// - Key values select self-programming or protected-write unlock.
// - Key reads show active modes in bits zero and one, rest zero.
module crg_core (
	input  wire logic                     clock,           // Processor clock
	input  wire logic                     rst,             // Synchronous reset, high
	// Register file port from the pipeline
	input  wire logic [4:0]               rf_rd_addr_a,    // Operand A register
	input  wire logic [4:0]               rf_rd_addr_b,    // Operand B register
	output logic      [7:0]               rf_rd_data_a,    // Operand A data
	output logic      [7:0]               rf_rd_data_b,    // Operand B data
	input  wire logic                     rf_wr_en,        // Result write strobe
	input  wire logic                     rf_wr_imm,       // Write from an immediate-form op
	input  wire logic [4:0]               rf_wr_addr,      // Result register
	input  wire logic [7:0]               rf_wr_data,      // Result data
	// Pointer port
	input  wire logic                     ptr_op_en,       // Pointer load or store strobe
	input  wire logic [1:0]               ptr_sel,         // Low, mid or high pair
	input  crg_pkg::crg_ptr_mode_type     ptr_mode,        // Addressing form
	input  wire logic [5:0]               ptr_disp,        // Displacement
	output logic      [15:0]              ptr_addr_reg,    // Effective data address
	output logic                          ptr_valid_reg,   // Effective address strobe
	input  wire logic                     prog_rd_en,      // Program memory read strobe
	output logic      [15:0]              prog_addr_reg,   // Program memory byte address
	output logic      [15:0]              pointer_low,     // Low pair word
	output logic      [15:0]              pointer_mid,     // Mid pair word
	output logic      [15:0]              pointer_high,    // High pair word
	// Core register block port
	input  wire logic [5:0]               io_addr,         // Core block offset
	input  wire logic                     io_wr,           // Write strobe
	input  wire logic                     io_rd,           // Read strobe
	input  wire logic [7:0]               io_wdata,        // Write data
	output logic      [7:0]               io_rdata_reg,    // Read data, next cycle
	// Execution events
	input  wire logic                     instr_retire,    // One instruction completed
	input  wire logic                     any_io_wr,       // Write to any I/O register
	input  wire logic                     dmem_wr,         // Write to data memory
	input  wire logic                     nvm_access,      // Flash, controller or EEPROM access
	input  wire logic                     sleep_exec,      // Sleep executed
	input  wire logic                     flags_upd_en,    // ALU flag update strobe
	input  wire logic [7:0]               flags_upd,       // ALU flags
	output logic                          io_write_unlock, // Protected writes allowed
	output logic                          self_program_unlock, // Self-programming allowed
	output logic                          irq_hold_reg,    // Interrupt dispatch held
	output logic      [7:0]               status_flags,    // Status register
	output logic      [15:0]              stack_pointer    // Stack pointer value
);

	logic [4:0]  wr_addr_eff;
	logic [7:0]  ptr_byte_reg [0:crg_pkg::PTR_BYTES-1];
	logic [15:0] sel_word;
	logic [15:0] eff_next;
	logic [15:0] wb_word;
	logic        wb_want;
	logic        pair_en;
	logic [4:0]  pair_addr;
	logic        sp_wr;
	logic        sp_rd;
	logic [7:0]  sp_rd_byte;
	logic        key_wr;
	logic        cancel_io;
	logic        cancel_spm;
	logic [2:0]  io_cnt_reg;
	logic [2:0]  io_cnt_next;
	logic [2:0]  spm_cnt_reg;
	logic [2:0]  spm_cnt_next;
	logic [2:0]  sp_hold_reg;
	logic [2:0]  sp_hold_next;
	logic        io_unlock_reg;
	logic        spm_unlock_reg;
	logic [7:0]  flags_reg;
	logic [7:0]  rd_next;

	function automatic logic [4:0] pair_base(input logic [1:0] sel);
		pair_base = 5'(crg_pkg::PTR_BASE + {2'h0, sel, 1'b0});
	endfunction

	function automatic logic [2:0] window_step(input logic [2:0] cnt, input logic load,
						   input logic cancel, input logic retire);
		if (load) begin
			window_step = crg_pkg::UNLOCK_INSTR;
		end else if (cancel) begin
			window_step = 3'h0;
		end else if (retire && cnt != 3'h0) begin
			window_step = 3'(cnt - 3'h1);
		end else begin
			window_step = cnt;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	// Force upper half
	assign wr_addr_eff = rf_wr_imm ? {1'b1, rf_wr_addr[3:0]} : rf_wr_addr;

	crg_regfile_mem u_mem (
		.clock     (clock),
		.rst       (rst),
		.wr_en     (rf_wr_en),
		.wr_addr   (wr_addr_eff),
		.wr_data   (rf_wr_data),
		.pair_en   (pair_en),
		.pair_addr (pair_addr),
		.pair_data (wb_word),
		.rd_addr_a (rf_rd_addr_a),
		.rd_addr_b (rf_rd_addr_b),
		.rd_data_a (rf_rd_data_a),
		.rd_data_b (rf_rd_data_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pointer pairs; a mirror of the top six bytes keeps the words on flops
	// Low byte at even address
	assign sel_word     = {ptr_byte_reg[{ptr_sel, 1'b1}], ptr_byte_reg[{ptr_sel, 1'b0}]};
	assign pointer_low  = {ptr_byte_reg[1], ptr_byte_reg[0]};
	assign pointer_mid  = {ptr_byte_reg[3], ptr_byte_reg[2]};
	assign pointer_high = {ptr_byte_reg[5], ptr_byte_reg[4]};

	always_comb begin
		eff_next = sel_word;
		wb_word  = sel_word;
		wb_want  = 1'b0;
		case (ptr_mode)
			crg_pkg::PTR_DISP: begin
				eff_next = 16'(sel_word + {10'h000, ptr_disp});
			end
			crg_pkg::PTR_POST_INC: begin
				wb_word = 16'(sel_word + 16'h0001);
				wb_want = 1'b1;
			end
			crg_pkg::PTR_PRE_DEC: begin
				wb_word  = 16'(sel_word - 16'h0001);
				eff_next = wb_word;
				wb_want  = 1'b1;
			end
			default: begin
				eff_next = sel_word;
			end
		endcase
	end

	// Select three is no pair, so it never writes back
	assign pair_en   = ptr_op_en && wb_want && ptr_sel != 2'h3;
	assign pair_addr = pair_base(ptr_sel);

	genvar i;
	generate
		for (i = 0; i < crg_pkg::PTR_BYTES; i++) begin : g_ptr
			localparam logic [4:0] BYTE_ADDR = 5'(crg_pkg::PTR_BASE + i);
			always_ff @(posedge clock) begin
				if (rst) begin
					ptr_byte_reg[i] <= 8'h00;
				end else if (rf_wr_en && wr_addr_eff == BYTE_ADDR) begin
					ptr_byte_reg[i] <= rf_wr_data;
				end else if (pair_en && pair_addr[4:1] == BYTE_ADDR[4:1]) begin
					ptr_byte_reg[i] <= BYTE_ADDR[0] ? wb_word[15:8] : wb_word[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			ptr_addr_reg  <= 16'h0000;
			ptr_valid_reg <= 1'b0;
		end else begin
			ptr_valid_reg <= ptr_op_en && ptr_sel != 2'h3;
			// Select three has no pair, so the last address stands
			if (ptr_op_en && ptr_sel != 2'h3) begin
				ptr_addr_reg <= eff_next;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prog_addr_reg <= 16'h0000;
		end else if (prog_rd_en) begin
			prog_addr_reg <= pointer_high;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stack pointer behind its staging byte
	assign sp_wr = io_wr && (io_addr == crg_pkg::OFS_SP_LOW || io_addr == crg_pkg::OFS_SP_HIGH);
	assign sp_rd = io_rd && (io_addr == crg_pkg::OFS_SP_LOW || io_addr == crg_pkg::OFS_SP_HIGH);

	crg_wide_stage #(
		.BYTES       (2),
		.RESET_VALUE (crg_pkg::SP_RESET)
	) u_sp (
		.clock     (clock),
		.rst       (rst),
		.wr_en     (sp_wr),
		.rd_en     (sp_rd),
		.byte_sel  (2'(io_addr - crg_pkg::OFS_SP_LOW)),
		.wdata     (io_wdata),
		.value_reg (stack_pointer),
		.rd_byte   (sp_rd_byte)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Protection key windows
	// Independent modes
	assign key_wr = io_wr && io_addr == crg_pkg::OFS_KEY;

	assign cancel_io  = io_wr || any_io_wr || dmem_wr || nvm_access || sleep_exec;
	assign cancel_spm = nvm_access || sleep_exec;

	assign io_cnt_next  = window_step(io_cnt_reg, key_wr && io_wdata == crg_pkg::SIG_IO_WRITE,
					  cancel_io, instr_retire);
	assign spm_cnt_next = window_step(spm_cnt_reg, key_wr && io_wdata == crg_pkg::SIG_SELF_PROG,
					  cancel_spm, instr_retire);

	// Stack low-byte write holds interrupts until four instructions or next I/O write
	always_comb begin
		if (io_wr && io_addr == crg_pkg::OFS_SP_LOW) begin
			sp_hold_next = crg_pkg::SP_HOLD_INSTR;
		end else if (io_wr || any_io_wr) begin
			sp_hold_next = 3'h0;
		end else if (instr_retire && sp_hold_reg != 3'h0) begin
			sp_hold_next = 3'(sp_hold_reg - 3'h1);
		end else begin
			sp_hold_next = sp_hold_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			io_cnt_reg     <= 3'h0;
			spm_cnt_reg    <= 3'h0;
			io_unlock_reg  <= 1'b0;
			spm_unlock_reg <= 1'b0;
		end else begin
			io_cnt_reg     <= io_cnt_next;
			spm_cnt_reg    <= spm_cnt_next;
			io_unlock_reg  <= io_cnt_next != 3'h0;
			spm_unlock_reg <= spm_cnt_next != 3'h0;
		end
	end

	assign io_write_unlock     = io_unlock_reg;
	assign self_program_unlock = spm_unlock_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			sp_hold_reg  <= 3'h0;
			irq_hold_reg <= 1'b0;
		end else begin
			sp_hold_reg  <= sp_hold_next;
			irq_hold_reg <= io_cnt_next != 3'h0 || spm_cnt_next != 3'h0 ||
					sp_hold_next != 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags; a software write wins over an ALU update in the same cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			flags_reg <= crg_pkg::FLAGS_RESET;
		end else if (io_wr && io_addr == crg_pkg::OFS_FLAGS) begin
			flags_reg <= io_wdata;
		end else if (flags_upd_en) begin
			flags_reg <= flags_upd;
		end
	end

	assign status_flags = flags_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Read data
	always_comb begin
		rd_next = 8'h00;
		case (io_addr)
			crg_pkg::OFS_KEY: begin
				rd_next[crg_pkg::KEY_IO_BIT]  = io_unlock_reg;
				rd_next[crg_pkg::KEY_SPM_BIT] = spm_unlock_reg;
			end
			crg_pkg::OFS_SP_LOW: begin
				rd_next = sp_rd_byte;
			end
			crg_pkg::OFS_SP_HIGH: begin
				rd_next = sp_rd_byte;
			end
			crg_pkg::OFS_FLAGS: begin
				rd_next = flags_reg;
			end
			default: begin
				rd_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			io_rdata_reg <= 8'h00;
		end else begin
			io_rdata_reg <= io_rd ? rd_next : 8'h00;
		end
	end

endmodule // crg_core

// [verif/crg_core_sva.sv]
// Port checker for the register file, wide access staging and unlock windows
`timescale 1ns/100ps
module crg_core_sva (
	input wire logic        clock,               // Clock
	input wire logic        rst,                 // Reset
	input wire logic [5:0]  io_addr,             // Offset
	input wire logic        io_wr,               // Write
	input wire logic        io_rd,               // Read
	input wire logic [7:0]  io_wdata,            // Write data
	input wire logic [7:0]  io_rdata_reg,        // Read data
	input wire logic        any_io_wr,           // Outside write
	input wire logic        dmem_wr,             // Memory write
	input wire logic        nvm_access,          // Memory access
	input wire logic        sleep_exec,          // Sleep
	input wire logic        io_write_unlock,     // Write window
	input wire logic        self_program_unlock, // Program window
	input wire logic        irq_hold_reg,        // Hold
	input wire logic [15:0] stack_pointer,       // Stack word
	input wire logic        ptr_op_en,           // Pointer op
	input wire logic [1:0]  ptr_sel,             // Pair
	input wire logic        ptr_valid_reg,       // Address strobe
	input wire logic        prog_rd_en,          // Program read
	input wire logic [15:0] prog_addr_reg,       // Program address
	input wire logic [15:0] pointer_high         // Top pair
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic rsvd;
	assign rsvd = !(io_addr inside {6'h04, 6'h0d, 6'h0e, 6'h0f});
	sequence sp_lo_wr; io_wr && io_addr == 6'h0d; endsequence
	sequence sp_hi_wr; io_wr && io_addr == 6'h0e; endsequence

	a_io_key_open: assert property (io_wr && io_addr == 6'h04 && io_wdata == 8'hd8
		|=> io_write_unlock && irq_hold_reg) else $error("write window did not open");
	a_spm_key_open: assert property (io_wr && io_addr == 6'h04 && io_wdata == 8'h9d
		|=> self_program_unlock) else $error("program window did not open");
	a_io_cancel: assert property (io_write_unlock && !io_wr
		&& (any_io_wr || dmem_wr || nvm_access || sleep_exec) |=> !io_write_unlock)
		else $error("write window not closed");
	a_spm_cancel: assert property (self_program_unlock && !io_wr
		&& (nvm_access || sleep_exec) |=> !self_program_unlock)
		else $error("program window not closed");
	a_sp_low_staged: assert property (sp_lo_wr |=> $stable(stack_pointer))
		else $error("low write changed stack word");
	a_sp_pair_commit: assert property (sp_lo_wr ##1 sp_hi_wr
		|=> stack_pointer == {$past(io_wdata), $past(io_wdata, 2)})
		else $error("stack word not committed");
	a_rsvd_read_zero: assert property (io_rd && rsvd |=> io_rdata_reg == 8'h00)
		else $error("reserved offset read nonzero");
	a_key_readback: assert property (io_rd && io_addr == 6'h04
		|=> io_rdata_reg == {6'h00, $past(self_program_unlock), $past(io_write_unlock)})
		else $error("key read wrong");
	a_prog_ptr: assert property (prog_rd_en |=> prog_addr_reg == $past(pointer_high))
		else $error("program address not top pair");
	a_ptr_refuse: assert property (ptr_op_en && ptr_sel == 2'h3 |=> !ptr_valid_reg)
		else $error("fourth pair select accepted");
endmodule // crg_core_sva

bind crg_core crg_core_sva crg_core_sva_i (.clock, .rst, .io_addr, .io_wr, .io_rd, .io_wdata,
	.io_rdata_reg, .any_io_wr, .dmem_wr, .nvm_access, .sleep_exec, .io_write_unlock,
	.self_program_unlock, .irq_hold_reg, .stack_pointer, .ptr_op_en, .ptr_sel,
	.ptr_valid_reg, .prog_rd_en, .prog_addr_reg, .pointer_high);

// [verif/crg_pipe_model.sv]
// Pipeline stand-in that retires instructions at a chosen pace
`timescale 1ns/100ps
module crg_pipe_model (
	input  wire logic       clock,        // Processor clock
	input  wire logic       start,        // Begin a run
	input  wire logic [2:0] count,        // Instructions in the run
	input  wire logic [1:0] gap,          // Idle cycles between retires
	output logic            instr_retire, // Retire pulse
	output logic            busy          // Run in progress
);
	logic [2:0] left_reg = 3'h0;
	logic [1:0] wait_reg = 2'h0;
	logic       fire_reg = 1'b0;
	initial instr_retire = 1'b0;
	assign busy = (left_reg != 3'h0) || fire_reg || instr_retire;
	always_ff @(posedge clock) begin
		if (start) begin
			left_reg <= count;
			wait_reg <= gap;
			fire_reg <= 1'b0;
		end else if (left_reg != 3'h0 && wait_reg == 2'h0) begin
			left_reg <= left_reg - 3'h1;
			wait_reg <= gap;
			fire_reg <= 1'b1;
		end else begin
			fire_reg <= 1'b0;
			if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
		end
	end
	// Launched off the falling edge like every other core input
	always @(negedge clock) instr_retire <= fire_reg;
endmodule // crg_pipe_model

// [verif/crg_core_tb_top.sv]
// Self-checking bench for the register file and wide access guard
`timescale 1ns/100ps
module crg_core_tb_top;
	localparam logic [9:0] W = 10'h200, R = 10'h100, RF = 10'h080, PT = 10'h040;
	localparam logic [9:0] PG = 10'h020, AIO = 10'h010, DM = 10'h008, NV = 10'h004;
	localparam logic [9:0] SL = 10'h002, FU = 10'h001;
	logic clock, rst, rf_wr_imm, prog_rd_en, rt_go, busy, ret, rd_seen;
	logic [9:0] stb;
	logic [4:0] rf_rd_addr_a, rf_rd_addr_b, rf_wr_addr;
	logic [7:0] rf_rd_data_a, rf_rd_data_b, rf_wr_data, io_wdata, io_rdata_reg, flags_upd;
	logic [7:0] status_flags, lo, hi, f, mem [32];
	logic [15:0] ptr_addr_reg, prog_addr_reg, pointer_low, pointer_mid, pointer_high;
	logic [15:0] stack_pointer, pw [3], ea, nw;
	logic [5:0] io_addr, ptr_disp;
	logic [1:0] ptr_sel, rt_gap;
	logic [2:0] rt_n;
	logic io_wr, io_rd, rf_wr_en, ptr_op_en, any_io_wr, dmem_wr, nvm_access, sleep_exec;
	logic flags_upd_en, ptr_valid_reg, io_write_unlock, self_program_unlock, irq_hold_reg;
	crg_pkg::crg_ptr_mode_type ptr_mode;
	logic [31:0] seed = 32'h96d7189e;
	logic [7:0] exq [$];
	logic [9:0] cx [4] = '{AIO, DM, NV, SL};
	int failures = 0, compares = 0, cyc = 0;
	assign {io_wr, io_rd, rf_wr_en, ptr_op_en, prog_rd_en} = stb[9:5];
	assign {any_io_wr, dmem_wr, nvm_access, sleep_exec, flags_upd_en} = stb[4:0];

	crg_core crg_core_i (.clock, .rst, .rf_rd_addr_a, .rf_rd_addr_b, .rf_rd_data_a,
		.rf_rd_data_b, .rf_wr_en, .rf_wr_imm, .rf_wr_addr, .rf_wr_data, .ptr_op_en, .ptr_sel,
		.ptr_mode, .ptr_disp, .ptr_addr_reg, .ptr_valid_reg, .prog_rd_en, .prog_addr_reg,
		.pointer_low, .pointer_mid, .pointer_high, .io_addr, .io_wr, .io_rd, .io_wdata,
		.io_rdata_reg, .instr_retire(ret), .any_io_wr, .dmem_wr, .nvm_access, .sleep_exec,
		.flags_upd_en, .flags_upd, .io_write_unlock, .self_program_unlock, .irq_hold_reg,
		.status_flags, .stack_pointer);
	crg_pipe_model crg_pipe_model_i (.clock, .start(rt_go), .count(rt_n), .gap(rt_gap),
		.instr_retire(ret), .busy);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function logic [7:0] rb();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task give_verdict;
		if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task p(input logic [9:0] s);
		stb = s;
		@(negedge clock);
	endtask
	task io(input logic [9:0] s, input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
		io_addr = a;
		io_wdata = d;
		if (s == R) exq.push_back(e);
		p(s);
	endtask
	task run(input logic [2:0] n, input logic [1:0] g);
		int t;
		t = 0;
		rt_n = n;
		rt_gap = g;
		rt_go = 1'b1;
		p(10'h0);
		rt_go = 1'b0;
		while (busy && t < 40) begin
			p(10'h0);
			t++;
		end
		if (busy) failures++;
		p(10'h0);
	endtask

	// Read results land one edge after the strobe
	always @(posedge clock) rd_seen <= io_rd && !rst;
	always @(negedge clock)
		if (rd_seen && exq.size() > 0) chk("io read", io_rdata_reg, exq.pop_front());
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			give_verdict;
		end
	end

	initial begin
		{stb, io_addr, io_wdata, rf_rd_addr_a, rf_rd_addr_b, rf_wr_addr, rf_wr_data} = '0;
		{rf_wr_imm, ptr_sel, ptr_disp, flags_upd, rt_go, rt_n, rt_gap} = '0;
		ptr_mode = crg_pkg::PTR_DISP;
		rst = 1'b1;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		chk("sp reset", stack_pointer, 16'hffff);
		chk("flags reset", status_flags, 16'h0);
		io(R, 6'h04, 8'h00, 8'h00);
		lo = rb();
		hi = rb();
		io(W, 6'h0d, lo, 8'h00);
		chk("sp low only", stack_pointer, 16'hffff);
		io(W, 6'h0e, hi, 8'h00);
		chk("sp pair", stack_pointer, {hi, lo});
		io(R, 6'h0d, 8'h00, lo);
		io(R, 6'h0e, 8'h00, hi);
		f = rb();
		io(W, 6'h0f, f, 8'h00);
		io(R, 6'h0f, 8'h00, f);
		flags_upd = rb();
		p(FU);
		chk("flags", status_flags, flags_upd);
		for (int i = 0; i < 64; i++) if (!(i inside {4, 13, 14, 15})) begin
			io(W, 6'(i), rb(), 8'h00);
			io(R, 6'(i), 8'h00, 8'h00);
		end
		chk("sp kept", stack_pointer, {hi, lo});
		chk("flags kept", status_flags, flags_upd);
		io(W, 6'h04, 8'h55, 8'h00);
		io(R, 6'h04, 8'h00, 8'h00);
		io(W, 6'h04, 8'hd8, 8'h00);
		chk("io unlock", io_write_unlock, 16'h1);
		chk("irq hold", irq_hold_reg, 16'h1);
		chk("spm idle", self_program_unlock, 16'h0);
		io(R, 6'h04, 8'h00, 8'h01);
		run(3'h3, 2'h2);
		chk("io open", io_write_unlock, 16'h1);
		run(3'h1, 2'h2);
		chk("io closed", io_write_unlock, 16'h0);
		chk("irq free", irq_hold_reg, 16'h0);
		for (int k = 0; k < 4; k++) begin
			io(W, 6'h04, 8'hd8, 8'h00);
			p(cx[k]);
			chk("io cancel", io_write_unlock, 16'h0);
		end
		for (int k = 2; k < 4; k++) begin
			io(W, 6'h04, 8'h9d, 8'h00);
			p(DM);
			chk("spm kept", self_program_unlock, 16'h1);
			p(cx[k]);
			chk("spm cancel", self_program_unlock, 16'h0);
		end
		io(W, 6'h04, 8'h9d, 8'h00);
		io(R, 6'h04, 8'h00, 8'h02);
		run(3'h4, 2'h0);
		chk("spm closed", self_program_unlock, 16'h0);
		for (int i = 0; i < 32; i++) begin
			mem[i] = rb();
			rf_wr_addr = 5'(i);
			rf_wr_data = mem[i];
			p(RF);
		end
		for (int i = 0; i < 32; i++) begin
			rf_rd_addr_a = 5'(i);
			rf_rd_addr_b = 5'(31 - i);
			p(10'h0);
			chk("rf a", rf_rd_data_a, mem[i]);
			chk("rf b", rf_rd_data_b, mem[31 - i]);
		end
		rf_wr_imm = 1'b1;
		rf_wr_addr = 5'h02;
		mem[18] = rb();
		rf_wr_data = mem[18];
		p(RF);
		rf_wr_imm = 1'b0;
		rf_rd_addr_a = 5'h12;
		rf_rd_addr_b = 5'h02;
		p(10'h0);
		chk("imm dest", rf_rd_data_a, mem[18]);
		chk("imm low kept", rf_rd_data_b, mem[2]);
		pw = '{{mem[27], mem[26]}, {mem[29], mem[28]}, {mem[31], mem[30]}};
		chk("pair low", pointer_low, pw[0]);
		chk("pair mid", pointer_mid, pw[1]);
		p(PG);
		chk("prog addr", prog_addr_reg, pw[2]);
		for (int s = 0; s < 3; s++) for (int m = 0; m < 4; m++) begin
			ptr_sel = 2'(s);
			ptr_mode = crg_pkg::crg_ptr_mode_type'(m);
			ptr_disp = 6'(rb());
			ea = (m == 0) ? pw[s] + 16'(ptr_disp) : (m == 2) ? pw[s] - 16'h1 : pw[s];
			nw = (m == 1) ? pw[s] + 16'h1 : (m == 2) ? pw[s] - 16'h1 : pw[s];
			pw[s] = nw;
			p(PT);
			chk("ptr valid", ptr_valid_reg, 16'h1);
			chk("ptr addr", ptr_addr_reg, ea);
			chk("ptr word", s == 0 ? pointer_low : s == 1 ? pointer_mid : pointer_high, nw);
		end
		ptr_sel = 2'h3;
		ptr_mode = crg_pkg::PTR_POST_INC;
		p(PT);
		chk("sel3 refused", ptr_valid_reg, 16'h0);
		chk("sel3 addr kept", ptr_addr_reg, ea);
		p(10'h0);
		give_verdict;
	end
endmodule // crg_core_tb_top
